// [design/cssw_clock_switch.sv]
// Clock source selection, glitch-free internal-to-external switch, x4/x2 clocks.
// Assumes a classic Wishbone master on clk_i and raw oscillator clocks as inputs.
`timescale 1ns/1ps
`include "cssw_consts.svh"

module cssw_clock_switch
  import cssw_pkg::*;
#(
  parameter int INT_FREQ_KHZ = `CSSW_INT_FREQ_KHZ  // Nominal internal rate
) (
  input  wire logic        clk_i,                  // Bus clock, 250 MHz
  input  wire logic        rst_i,                  // Reset, high; synchronous on clk_i, asynchronous in the source clock domains
  input  wire logic [31:0] wb_adr_i,               // Wishbone address
  input  wire logic [31:0] wb_dat_i,               // Wishbone write data
  output logic      [31:0] wb_dat_o,               // Wishbone read data
  input  wire logic        wb_we_i,                // Wishbone write enable
  input  wire logic [3:0]  wb_sel_i,               // Wishbone byte selects
  input  wire logic        wb_cyc_i,               // Wishbone cycle
  input  wire logic        wb_stb_i,               // Wishbone strobe
  output logic             wb_ack_o,               // Wishbone acknowledge
  input  wire logic        internal_source_clock,  // Internal oscillator clock
  input  wire logic        rc_source_clock,        // RC oscillator clock
  input  wire logic        crystal_source_clock,   // Crystal amplifier clock
  input  wire logic        clock_in_pin_i,         // Clock input pin level
  input  wire logic        osc_run_enable_i,       // Oscillator enable from system
  input  wire logic        stop_mode_i,            // Stop mode request
  input  wire logic        bypass_mode_i,          // Monitor mode, internal bypassed
  input  wire logic        port_a_pin4_i,          // Port pin 4 output data
  input  wire logic        port_a_pin4_oe_i,       // Port pin 4 output enable
  output logic             clock_x4_out_o,         // Selected source clock
  output logic             clock_x2_out_o,         // Half-rate clock
  output logic             clock_out_pin_o,        // Clock-out pin data
  output logic             clock_out_pin_oe_o,     // Clock-out pin drive enable
  output logic             clock_in_pin_ie_o,      // Clock-in pin used as clock input
  output logic             crystal_amp_en_o,       // Crystal amplifier on
  output logic             internal_osc_en_o,      // Internal oscillator on
  output logic             rc_osc_en_o             // RC oscillator on
);

  // Frequency is informative only; the gates never depend on it
  if (INT_FREQ_KHZ <= 0) begin : g_bad_freq
    $error("INT_FREQ_KHZ must be positive");
  end

  // ==========================================================================
  // Register bus
  // ==========================================================================
  logic [1:0]  source_select_r;
  logic [1:0]  source_select_nxt;
  logic        clock_out_enable_r;
  logic        clock_out_enable_nxt;
  logic        ext_gen_enable_r;
  logic        ext_gen_enable_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        engaged_s1_r;
  logic        engaged_s2_r;
  cssw_src_t   src;
  logic        req;
  logic        wr;

  // Ack blocks a second take of the same request
  assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign src      = cssw_src_t'(source_select_r);
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  always_comb begin
    source_select_nxt    = source_select_r;
    clock_out_enable_nxt = clock_out_enable_r;
    ext_gen_enable_nxt   = ext_gen_enable_r;
    ack_nxt              = req;
    rdata_nxt            = 32'h0;
    // Engaged bit is read-only: only bit 0 is taken
    if (wr && wb_adr_i[3:0] == `CSSW_OFS_STATUS) begin
      ext_gen_enable_nxt = wb_dat_i[`CSSW_BIT_EXT_GEN] & ~bypass_mode_i;
    end
    // Source is frozen once the switch is requested or engaged: the mux
    // feeding the running clock must never move under it
    if (wr && wb_adr_i[3:0] == `CSSW_OFS_CONFIG
        && !ext_gen_enable_r && !engaged_s2_r) begin
      source_select_nxt    = wb_dat_i[`CSSW_SEL_MSB:`CSSW_SEL_LSB];
      clock_out_enable_nxt = wb_dat_i[`CSSW_BIT_OUT_EN];
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i[3:0])
        `CSSW_OFS_STATUS: begin
          rdata_nxt[`CSSW_BIT_EXT_GEN] = ext_gen_enable_r;
          rdata_nxt[`CSSW_BIT_ENGAGED] = engaged_s2_r;
        end
        `CSSW_OFS_CONFIG: begin
          rdata_nxt[`CSSW_SEL_MSB:`CSSW_SEL_LSB] = source_select_r;
          rdata_nxt[`CSSW_BIT_OUT_EN]           = clock_out_enable_r;
        end
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      source_select_r    <= `CSSW_RST_SEL;
      clock_out_enable_r <= 1'b0;
      ext_gen_enable_r   <= 1'b0;
      ack_r              <= 1'b0;
      rdata_r            <= 32'h0;
    end else begin
      source_select_r    <= source_select_nxt;
      clock_out_enable_r <= clock_out_enable_nxt;
      ext_gen_enable_r   <= ext_gen_enable_nxt;
      ack_r              <= ack_nxt;
      rdata_r            <= rdata_nxt;
    end
  end

  // ==========================================================================
  // External clock domain: request sync and activity check
  // ==========================================================================
  logic        ext_clk;
  logic        req_s1_r;
  logic        req_s2_r;
  logic [1:0]  edge_cnt_r;
  logic [1:0]  edge_cnt_nxt;
  cssw_state_t sw_state_r;
  cssw_state_t sw_state_nxt;
  logic        ext_sel_r;
  logic        ext_sel_nxt;
  logic        ext_on_r;

  always_comb begin
    case (src)
      CSSW_SRC_EXTCLK:  ext_clk = clock_in_pin_i;
      CSSW_SRC_RC:      ext_clk = rc_source_clock;
      CSSW_SRC_CRYSTAL: ext_clk = crystal_source_clock;
      default:          ext_clk = 1'b0;
    endcase
  end

  // Switch sequence: request seen, source proven by edges, handover, done
  always_comb begin
    sw_state_nxt = sw_state_r;
    edge_cnt_nxt = edge_cnt_r;
    ext_sel_nxt  = ext_sel_r;
    case (sw_state_r)
      CSSW_ST_INT: begin
        edge_cnt_nxt = 2'h0;
        if (req_s2_r) begin
          sw_state_nxt = CSSW_ST_WAIT;
        end
      end
      CSSW_ST_WAIT: begin
        // Request withdrawn before the source proved alive: stay internal
        if (!req_s2_r) begin
          sw_state_nxt = CSSW_ST_INT;
        end else if (edge_cnt_r == `CSSW_EDGES_NEEDED) begin
          sw_state_nxt = CSSW_ST_HAND;
          ext_sel_nxt  = 1'b1;
        end else begin
          edge_cnt_nxt = edge_cnt_r + 2'h1;
        end
      end
      CSSW_ST_HAND: begin
        if (ext_on_r) begin
          sw_state_nxt = CSSW_ST_EXT;
        end
      end
      CSSW_ST_EXT: begin
        // No clock monitor: a dead external source is not detected
        sw_state_nxt = CSSW_ST_EXT;
      end
      default: begin
        sw_state_nxt = CSSW_ST_INT;
        ext_sel_nxt  = 1'b0;
      end
    endcase
  end

  // Asynchronous reset: with the internal source selected this clock stands
  // still, and release is safe because the source is internal by then
  always_ff @(posedge ext_clk or posedge rst_i) begin
    if (rst_i) begin
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      edge_cnt_r <= 2'h0;
      sw_state_r <= CSSW_ST_INT;
      ext_sel_r  <= 1'b0;
    end else begin
      req_s1_r   <= ext_gen_enable_r;
      req_s2_r   <= req_s1_r;
      edge_cnt_r <= edge_cnt_nxt;
      sw_state_r <= sw_state_nxt;
      ext_sel_r  <= ext_sel_nxt;
    end
  end

  // ==========================================================================
  // Glitch-free handover: internal side releases on its own falling edge,
  // external side engages on its falling edge only after internal is off
  // ==========================================================================
  logic int_on_r;
  logic int_gate_r;
  logic ext_gate_r;

  // Internal gate closes while its clock is low, so no runt high phase
  always_ff @(negedge internal_source_clock or posedge rst_i) begin
    if (rst_i) begin
      int_on_r   <= 1'b1;
      int_gate_r <= 1'b1;
    end else begin
      int_on_r   <= ~ext_sel_r;
      int_gate_r <= int_on_r & ~ext_sel_r;
    end
  end

  // Opens only after the internal gate is seen closed on this clock
  always_ff @(negedge ext_clk or posedge rst_i) begin
    if (rst_i) begin
      ext_on_r   <= 1'b0;
      ext_gate_r <= 1'b0;
    end else begin
      ext_on_r   <= ext_sel_r & ~int_gate_r;
      ext_gate_r <= ext_on_r;
    end
  end

  // Engaged bit crosses to the bus domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      engaged_s1_r <= 1'b0;
      engaged_s2_r <= 1'b0;
    end else begin
      engaged_s1_r <= ext_gate_r;
      engaged_s2_r <= engaged_s1_r;
    end
  end

  // ==========================================================================
  // Clock outputs
  // ==========================================================================
  logic src_clk;
  logic x2_r;

  // Stop gates the source; wait and break have no effect here
  assign src_clk        = (internal_source_clock & int_gate_r)
                        | (ext_clk & ext_gate_r);
  assign clock_x4_out_o = src_clk & ~stop_mode_i;

  // Follows x4 rises, so it halts with x4 in stop mode
  always_ff @(posedge clock_x4_out_o or posedge rst_i) begin
    if (rst_i) x2_r <= 1'b0;
    else       x2_r <= ~x2_r;
  end
  assign clock_x2_out_o = x2_r;

  // Internal oscillator stops once engaged is set, in stop mode, or while run enable is low
  assign internal_osc_en_o = osc_run_enable_i & ~engaged_s2_r & ~stop_mode_i;
  assign rc_osc_en_o       = osc_run_enable_i & (src == CSSW_SRC_RC) & ~stop_mode_i;
  assign crystal_amp_en_o  = osc_run_enable_i & (src == CSSW_SRC_CRYSTAL)
                           & ~stop_mode_i;
  assign clock_in_pin_ie_o = (src != CSSW_SRC_INTERNAL);

  // Crystal owns the pin; pin clock source always gives pin 4; otherwise pin 4 unless clock out is enabled
  always_comb begin
    case (src)
      CSSW_SRC_CRYSTAL: begin
        clock_out_pin_o    = ~crystal_source_clock;
        clock_out_pin_oe_o = 1'b1;
      end
      CSSW_SRC_EXTCLK: begin
        clock_out_pin_o    = port_a_pin4_i;
        clock_out_pin_oe_o = port_a_pin4_oe_i;
      end
      default: begin
        clock_out_pin_o    = clock_out_enable_r ? clock_x4_out_o : port_a_pin4_i;
        clock_out_pin_oe_o = clock_out_enable_r | port_a_pin4_oe_i;
      end
    endcase
  end

endmodule // cssw_clock_switch

// [design/cssw_consts.svh]
// Constants for the clock source select and switch block.
// Assumes inclusion by the package and the design module only.
`ifndef CSSW_CONSTS_SVH
`define CSSW_CONSTS_SVH
// Register byte offsets (32-bit words)
`define CSSW_OFS_STATUS   4'h0
`define CSSW_OFS_CONFIG   4'h4
`define CSSW_OFS_CTRL     4'h8
// Status register fields
`define CSSW_BIT_EXT_GEN  0
`define CSSW_BIT_ENGAGED  1
// Config register fields
`define CSSW_SEL_LSB      0
`define CSSW_SEL_MSB      1
`define CSSW_BIT_OUT_EN   2
// Control register fields
`define CSSW_BIT_PIN4     0
`define CSSW_BIT_PIN4_OE  1
// Reset values
`define CSSW_RST_SEL      2'h0
// Activity check: external rising edges before switching
`define CSSW_EDGES_NEEDED 2'h2
// Nominal internal oscillator, in kHz
`define CSSW_INT_FREQ_KHZ 4000
`endif

// [design/cssw_pkg.sv]
// Types for the clock source select and switch block.
// Assumes cssw_consts.svh sits beside it.
package cssw_pkg;
  `include "cssw_consts.svh"
  typedef enum logic [1:0] {
    CSSW_SRC_INTERNAL = 2'h0,
    CSSW_SRC_EXTCLK   = 2'h1,
    CSSW_SRC_RC       = 2'h2,
    CSSW_SRC_CRYSTAL  = 2'h3
  } cssw_src_t;
  typedef enum logic [3:0] {
    CSSW_ST_INT   = 4'h1,
    CSSW_ST_WAIT  = 4'h2,
    CSSW_ST_HAND  = 4'h4,
    CSSW_ST_EXT   = 4'h8
  } cssw_state_t;
endpackage

// [verification/cssw_clock_switch_properties.sv]
// Port-level checker for the clock source switch.
// Assumes every source clock phase spans at least two clk_i cycles.
`timescale 1ns/1ps
module cssw_clock_switch_props
  import cssw_pkg::*;
(
  input wire logic        clk_i,                 // Bus clock
  input wire logic        rst_i,                 // Reset
  input wire logic [31:0] wb_adr_i,              // Address
  input wire logic [31:0] wb_dat_i,              // Write data
  input wire logic        wb_we_i,               // Write
  input wire logic [3:0]  wb_sel_i,              // Selects
  input wire logic        wb_cyc_i,              // Cycle
  input wire logic        wb_stb_i,              // Strobe
  input wire logic        wb_ack_o,              // Ack
  input wire logic        internal_source_clock, // Internal clock
  input wire logic        crystal_source_clock,  // Crystal clock
  input wire logic        clock_in_pin_i,        // Pin clock
  input wire logic        osc_run_enable_i,      // Run enable
  input wire logic        stop_mode_i,           // Stop
  input wire logic        bypass_mode_i,         // Bypass
  input wire logic        port_a_pin4_i,         // Pin4 data
  input wire logic        port_a_pin4_oe_i,      // Pin4 enable
  input wire logic        clock_x4_out_o,        // x4 clock
  input wire logic        clock_x2_out_o,        // x2 clock
  input wire logic        clock_out_pin_o,       // Out pin
  input wire logic        clock_out_pin_oe_o,    // Out pin enable
  input wire logic        clock_in_pin_ie_o,     // In pin enable
  input wire logic        internal_osc_en_o      // Internal osc on
);
  logic [2:0] cfg_r, cfg_nxt;
  logic [1:0] edg_r, edg_nxt, mode_r;
  logic [7:0] calm_r, calm_nxt;
  logic       gen_r, gen_nxt, pin_r, wr_go;
  // ==========
  // Mirror of settings; calm counts cycles since stop or run last moved
  always_comb begin
    wr_go    = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    cfg_nxt  = (wr_go && wb_adr_i == 32'h4 && !gen_r) ? wb_dat_i[2:0] : cfg_r;
    gen_nxt  = (wr_go && wb_adr_i == 32'h0) ? (wb_dat_i[0] && !bypass_mode_i) : gen_r;
    edg_nxt  = edg_r + {1'b0, gen_r && clock_in_pin_i && !pin_r && edg_r != 2'h3};
    calm_nxt = ({stop_mode_i, osc_run_enable_i} != mode_r) ? 8'h00
             : calm_r + {7'h0, calm_r != 8'hFF};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {cfg_r, gen_r, edg_r, calm_r} <= '0;
    end else begin
      {cfg_r, gen_r, edg_r, calm_r} <= {cfg_nxt, gen_nxt, edg_nxt, calm_nxt};
    end
    pin_r  <= clock_in_pin_i;
    mode_r <= {stop_mode_i, osc_run_enable_i};
  end
  // ==========
  // Properties
  a_select_input: assert property (@(posedge clk_i) disable iff (rst_i)
    clock_in_pin_ie_o == (cfg_r[1:0] != CSSW_SRC_INTERNAL)) else $error("input enable wrong");
  a_pin_function: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_r[1:0] == CSSW_SRC_CRYSTAL) ? (clock_out_pin_oe_o && clock_out_pin_o == !crystal_source_clock)
    : (cfg_r[1:0] != CSSW_SRC_EXTCLK && cfg_r[2]) ? (clock_out_pin_oe_o && clock_out_pin_o == clock_x4_out_o)
    : (clock_out_pin_oe_o == port_a_pin4_oe_i && clock_out_pin_o == port_a_pin4_i))
    else $error("out pin function wrong");
  a_x4_internal: assert property (@(posedge clk_i) disable iff (rst_i)
    !gen_r && calm_r > 8'h96 && osc_run_enable_i && !stop_mode_i |->
    clock_x4_out_o == internal_source_clock) else $error("x4 not internal");
  a_wait_edges: assert property (@(posedge clk_i) disable iff (rst_i)
    gen_r && edg_r < 2'h2 && calm_r > 8'h96 && osc_run_enable_i && !stop_mode_i |->
    clock_x4_out_o == internal_source_clock) else $error("switched too early");
  a_ext_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    gen_r && !internal_osc_en_o && cfg_r[1:0] == CSSW_SRC_EXTCLK && calm_r > 8'h96
    && osc_run_enable_i && !stop_mode_i |-> clock_x4_out_o == clock_in_pin_i)
    else $error("x4 not pin clock");
  a_x2_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(clock_x2_out_o) == $rose(clock_x4_out_o)) else $error("x2 not half of x4");
  a_stop_halts: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_mode_i && calm_r > 8'h96 |-> !clock_x4_out_o) else $error("x4 runs in stop");
  a_run_gates: assert property (@(posedge clk_i) disable iff (rst_i)
    !osc_run_enable_i |-> !internal_osc_en_o) else $error("internal osc not gated");
endmodule // cssw_clock_switch_props

bind cssw_clock_switch cssw_clock_switch_props u_cssw_clock_switch_props (
  .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .internal_source_clock, .crystal_source_clock, .clock_in_pin_i,
  .osc_run_enable_i, .stop_mode_i, .bypass_mode_i, .port_a_pin4_i, .port_a_pin4_oe_i,
  .clock_x4_out_o, .clock_x2_out_o, .clock_out_pin_o, .clock_out_pin_oe_o,
  .clock_in_pin_ie_o, .internal_osc_en_o);

// [verification/cssw_ext_source.sv]
// External sources: pin clock generator, RC network and crystal.
// Assumes the bench starts and stops the pin generator.
`timescale 1ns/1ps
module cssw_ext_source (
  input  wire logic run_i,     // Pin generator running
  input  wire logic rc_en_i,   // RC network powered
  input  wire logic amp_en_i,  // Crystal amplifier powered
  output logic      pin_o,     // Clock pin
  output logic      rc_o,      // RC clock
  output logic      xtal_o     // Crystal clock
);
  logic osc_r = 1'b0;
  // Half-ns offset keeps source edges off every bench edge
  initial begin
    #0.5;
    forever #10 osc_r = ~osc_r;
  end
  assign pin_o  = run_i && osc_r;
  assign rc_o   = rc_en_i && osc_r;
  assign xtal_o = amp_en_i && osc_r;
endmodule // cssw_ext_source

// [verification/tb_top.sv]
// Self-checking bench for the clock source switch.
// Assumes the checker is bound and the source model stands at the pins.
`timescale 1ns/1ps
module tb_top;
  import cssw_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        osc_run_enable_i = 1'b1, stop_mode_i = 1'b0, bypass_mode_i = 1'b0, ext_run = 1'b1;
  logic        port_a_pin4_i = 1'b0, port_a_pin4_oe_i = 1'b0, internal_source_clock = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, d;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [2:0]  cfg;
  logic        wb_ack_o, clock_x4_out_o, clock_x2_out_o, clock_out_pin_o, clock_out_pin_oe_o;
  logic        clock_in_pin_ie_o, crystal_amp_en_o, internal_osc_en_o, rc_osc_en_o;
  logic        clock_in_pin_i, rc_source_clock, crystal_source_clock;
  int          seed = 32'hAE2E, n_mismatch = 0, compares = 0, n;
  cssw_clock_switch u_cssw_clock_switch (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .internal_source_clock,
    .rc_source_clock, .crystal_source_clock, .clock_in_pin_i, .osc_run_enable_i,
    .stop_mode_i, .bypass_mode_i, .port_a_pin4_i, .port_a_pin4_oe_i, .clock_x4_out_o,
    .clock_x2_out_o, .clock_out_pin_o, .clock_out_pin_oe_o, .clock_in_pin_ie_o,
    .crystal_amp_en_o, .internal_osc_en_o, .rc_osc_en_o);
  cssw_ext_source u_cssw_ext_source (.run_i(ext_run), .rc_en_i(rc_osc_en_o),
    .amp_en_i(crystal_amp_en_o), .pin_o(clock_in_pin_i), .rc_o(rc_source_clock),
    .xtal_o(crystal_source_clock));
  initial forever #2 clk_i = ~clk_i;
  // Internal oscillator, 4 MHz nominal, stands low while disabled
  initial begin
    #0.5;
    forever #125 internal_source_clock = (internal_osc_en_o === 1'b1) && !internal_source_clock;
  end
  task automatic give_verdict;
    $display("compares %0d, n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [31:0] adr, dat, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, dat};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (k >= 50) begin
      n_mismatch++;
      give_verdict;
    end
  endtask
  task automatic rdchk(input logic [31:0] adr, exp);
    bus(1'b0, adr, 32'h0, d);
    check(d, exp);
  endtask
  function automatic logic [1:0] pin_exp(input logic [2:0] c);
    if (c[1:0] == CSSW_SRC_CRYSTAL) return {1'b1, ~crystal_source_clock};
    if (c[1:0] != CSSW_SRC_EXTCLK && c[2]) return {1'b1, internal_source_clock};
    return {port_a_pin4_oe_i, port_a_pin4_i};
  endfunction
  function automatic logic [31:0] en_exp(input logic [1:0] s);
    return {30'h0, s == 2'h3, s == 2'h2};
  endfunction
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 32'h0, 32'h2, d);
    rdchk(32'h0, 32'h0);
    rdchk(32'h4, 32'h0);
    rdchk(32'h3C, 32'h0);
    // Every source code, out enable both ways, random pin4 and settle time
    for (int i = 0; i < 8; i++) begin
      cfg = 3'(i);
      bus(1'b1, 32'h4, {29'h0, cfg}, d);
      port_a_pin4_i <= 1'($random(seed));
      port_a_pin4_oe_i <= 1'($random(seed));
      rdchk(32'h4, {29'h0, cfg});
      repeat (($random(seed) & 32'h3F) + 1) @(posedge clk_i);
      @(negedge clk_i);
      check({31'h0, clock_in_pin_ie_o}, {31'h0, cfg[1:0] != 2'h0});
      check({30'h0, clock_out_pin_oe_o, clock_out_pin_o}, {30'h0, pin_exp(cfg)});
      check({30'h0, crystal_amp_en_o, rc_osc_en_o}, en_exp(cfg[1:0]));
    end
    // Stop mode, then run enable low: x4 must stand low
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      {stop_mode_i, osc_run_enable_i} <= (i == 0) ? 2'h3 : 2'h0;
      repeat (200) @(posedge clk_i);
      @(negedge clk_i);
      check({29'h0, clock_x4_out_o, crystal_amp_en_o, rc_osc_en_o}, 32'h0);
      @(posedge clk_i);
      {stop_mode_i, osc_run_enable_i} <= 2'h1;
    end
    bypass_mode_i <= 1'b1;
    bus(1'b1, 32'h0, 32'h1, d);
    rdchk(32'h0, 32'h0);
    bypass_mode_i <= 1'b0;
    // Precharge via pin4, select pin clock, settle 4096 source cycles, switch
    {port_a_pin4_oe_i, port_a_pin4_i} <= 2'h3;
    bus(1'b1, 32'h4, 32'h1, d);
    repeat (20480) @(posedge clk_i);
    bus(1'b1, 32'h0, 32'h1, d);
    n = 0;
    do begin
      bus(1'b0, 32'h0, 32'h0, d);
      n++;
    end while (d[1] !== 1'b1 && n < 100);
    check(d, 32'h3);
    check({31'h0, internal_osc_en_o}, 32'h0);
    bus(1'b1, 32'h4, 32'h3, d);
    rdchk(32'h4, 32'h1);
    ext_run <= 1'b0;
    repeat (100) @(posedge clk_i);
    rdchk(32'h0, 32'h3);
    check({31'h0, internal_osc_en_o}, 32'h0);
    ext_run <= 1'b1;
    rst_i <= 1'b1;
    repeat (32) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(32'h0, 32'h0);
    check({31'h0, internal_osc_en_o}, 32'h1);
    // Let the checker watch the restarted internal clock
    repeat (200) @(posedge clk_i);
    give_verdict;
  end
endmodule // tb_top
